// file: src/dsc_core.sv
// synthesizer core: bus slave, modulation fifo, phase accumulator, scaling, compensation filter
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// modulation sample fifo
// ****************************************
module dsc_fifo #(
	parameter int W = 34,
	parameter int D = 16
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              in_valid,
	input  wire logic [W-1:0]      in_data,
	output logic                   in_ready,
	output logic                   out_valid,
	output logic [W-1:0]           out_data,
	input  wire logic              out_ready,
	output logic [$clog2(D):0]     level
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [0:D-1];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0]   cnt_q;
	logic [AW:0]   cnt_d;
	logic          ready_q;
	wire           push = in_valid & ready_q;
	wire           pop  = out_valid & out_ready;

	assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	assign in_ready  = ready_q;
	assign out_valid = cnt_q != '0;
	assign out_data  = mem[rd_q];
	assign level     = cnt_q;

	always_ff @(posedge clk) begin
		if (push)
			mem[wr_q] <= in_data;
	end

	// ready is registered from the next count, so a full fifo refuses at once
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q    <= '0;
			rd_q    <= '0;
			cnt_q   <= '0;
			ready_q <= 1'b0;
		end else begin
			wr_q    <= wr_q + AW'(push);
			rd_q    <= rd_q + AW'(pop);
			cnt_q   <= cnt_d;
			ready_q <= cnt_d != (AW+1)'(D);
		end
	end
endmodule

module dsc_core
	import dsc_pkg::*;
(
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic [7:0]      paddr,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [31:0]     pwdata,
	output logic [31:0]          prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire logic            mod_valid,
	input  wire dsc_mod_sample_t mod_sample,
	output logic                 mod_ready,
	output logic [13:0]          dac_pos,
	output logic [13:0]          dac_neg,
	output logic [7:0]           fsc_code
);

	function automatic dsc_reg_t dsc_decode(input logic [7:0] a);
		if (a == OFS_CTRL)
			return REG_CTRL;
		else if (a == OFS_TUNE)
			return REG_TUNE;
		else if (a == OFS_PHASE)
			return REG_PHASE;
		else if (a == OFS_SCALE)
			return REG_SCALE;
		else if (a == OFS_AUX)
			return REG_AUX;
		else if (a == OFS_STAT)
			return REG_STAT;
		else
			return REG_NONE;
	endfunction

	function automatic logic [13:0] dsc_sat(input logic signed [31:0] v);
		if (v > 32'sd8191)
			return 14'h1fff;
		else if (v < -32'sd8191)
			return 14'h2001;
		else
			return v[13:0];
	endfunction

	// ****************************************
	// register file
	// ****************************************
	logic [31:0]     ctrl_q;
	logic [31:0]     tune_q;
	logic [15:0]     phase_ofs_q;
	logic [13:0]     scale_q;
	logic [7:0]      aux_q;
	logic [31:0]     prdata_q;
	logic            pready_q;
	logic            pslverr_q;
	logic [31:0]     acc_q;
	logic [4:0]      fifo_level;
	logic [31:0]     rd_mux;

	wire dsc_reg_t   idx   = dsc_decode(paddr);
	wire             setup = psel & ~penable;
	wire             wr_en = psel & penable & pready_q & pwrite;

	assign rd_mux = (idx == REG_CTRL) ? ctrl_q :
		(idx == REG_TUNE)  ? tune_q :
		(idx == REG_PHASE) ? {16'h0000, phase_ofs_q} :
		(idx == REG_SCALE) ? {18'h00000, scale_q} :
		(idx == REG_AUX)  ? {24'h000000, aux_q} :
		(idx == REG_STAT) ? {acc_q[31:16], 11'h000, fifo_level} : 32'h0000_0000;

	// no wait states: ready raised in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup & (idx == REG_NONE);
			if (setup)
				prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RST;
			tune_q      <= TUNE_RST;
			phase_ofs_q <= PHASE_RST;
			scale_q     <= SCALE_RST;
			aux_q       <= AUX_RST;
		end else if (wr_en) begin
			if (idx == REG_CTRL)
				ctrl_q <= pwdata;
			else if (idx == REG_TUNE)
				tune_q <= pwdata;
			else if (idx == REG_PHASE)
				phase_ofs_q <= pwdata[15:0];
			else if (idx == REG_SCALE)
				scale_q <= pwdata[13:0];
			else if (idx == REG_AUX)
				aux_q <= pwdata[7:0];
		end
	end

	assign prdata   = prdata_q;
	assign pready   = pready_q;
	assign pslverr  = pslverr_q;
	assign fsc_code = aux_q;

	// ****************************************
	// modulation path
	// ****************************************
	wire             mod_en = ctrl_q[CTRL_MOD_EN_BIT];
	logic [1:0]      gap_q;
	logic            fifo_valid;
	dsc_mod_sample_t fifo_out;
	logic [31:0]     wk_tune_q;
	logic [15:0]     wk_phase_q;
	logic [13:0]     wk_scale_q;

	// drain paced to one sample per four clocks
	wire             drain = mod_en & (gap_q == 2'h0);
	wire             pop   = drain & fifo_valid;

	dsc_fifo #(
		.W ($bits(dsc_mod_sample_t)),
		.D (FIFO_DEPTH)
	) u_fifo (
		.clk       (pclk),
		.rst_n     (presetn),
		.in_valid  (mod_valid),
		.in_data   (mod_sample),
		.in_ready  (mod_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_out),
		.out_ready (drain),
		.level     (fifo_level)
	);

	// with modulation off the stream stalls and registers steer the core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_q      <= 2'h0;
			wk_tune_q  <= TUNE_RST;
			wk_phase_q <= PHASE_RST;
			wk_scale_q <= SCALE_RST;
		end else if (!mod_en) begin
			gap_q      <= 2'h0;
			wk_tune_q  <= tune_q;
			wk_phase_q <= phase_ofs_q;
			wk_scale_q <= scale_q;
		end else begin
			gap_q <= pop ? MOD_DIV : gap_q - 2'(gap_q != 2'h0);
			if (pop && fifo_out.dest == DEST_FREQ)
				wk_tune_q <= fifo_out.value;
			if (pop && fifo_out.dest == DEST_PHASE)
				wk_phase_q <= fifo_out.value[15:0];
			if (pop && fifo_out.dest == DEST_AMP)
				wk_scale_q <= fifo_out.value[13:0];
		end
	end

	// ****************************************
	// phase and amplitude
	// ****************************************
	logic signed [13:0] amp_q;
	logic signed [13:0] scl_q;
	logic [15:0]        phase;
	logic [15:0]        pos_c;
	logic [15:0]        rem_c;
	logic [31:0]        par_c;
	logic [13:0]        mag_c;
	logic signed [28:0] scl_c;

	// offset added ahead of conversion; cosine is a quarter turn ahead
	assign phase = acc_q[31:16] + wk_phase_q + (ctrl_q[CTRL_SINE_BIT] ? 16'h0000 : QUARTER_TURN);
	// parabolic half-wave: cheap, no table, costs some harmonic purity
	assign pos_c = {1'b0, phase[14:0]};
	assign rem_c = HALF_TURN - pos_c;
	assign par_c = pos_c * rem_c;
	assign mag_c = par_c[28] ? MAG_MAX : {1'b0, par_c[27:15]};
	// scale by factor over two to fourteen
	assign scl_c = amp_q * $signed({1'b0, wk_scale_q});

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= 32'h0000_0000;
			amp_q <= 14'sh0000;
			scl_q <= 14'sh0000;
		end else begin
			acc_q <= acc_q + wk_tune_q;
			amp_q <= phase[15] ? -$signed(mag_c) : $signed(mag_c);
			scl_q <= scl_c[27:14];
		end
	end

	// ****************************************
	// compensation filter and dac
	// ****************************************
	logic signed [13:0] tap_q [0:6];
	logic signed [31:0] part [0:3];
	logic signed [31:0] fir_sum;
	logic signed [31:0] fir_norm;
	logic [13:0]        out_c;
	logic [13:0]        dac_pos_q;
	logic [13:0]        dac_neg_q;

	// symmetric pairs share one multiplier each
	genvar k;
	generate
		for (k = 0; k < 3; k++) begin : g_pair
			assign part[k] = FIR_TAP[k] * (32'(tap_q[k]) + 32'(tap_q[6-k]));
		end
	endgenerate
	assign part[3]  = FIR_TAP[3] * 32'(tap_q[3]);
	assign fir_sum  = part[0] + part[1] + part[2] + part[3];
	// tap sum 5803 over 8192 gives about -3 dB
	assign fir_norm = fir_sum >>> FIR_SHIFT;
	// bypass takes the centre tap so latency does not jump
	assign out_c    = ctrl_q[CTRL_ISINC_BIT] ? dsc_sat(fir_norm) : tap_q[3];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 7; i++)
				tap_q[i] <= 14'sh0000;
			dac_pos_q <= DAC_MIDSCALE;
			dac_neg_q <= ~DAC_MIDSCALE;
		end else begin
			tap_q[0] <= scl_q;
			for (int i = 1; i < 7; i++)
				tap_q[i] <= tap_q[i-1];
			// offset binary pair, negative leg complemented
			dac_pos_q <= out_c ^ DAC_MIDSCALE;
			dac_neg_q <= ~(out_c ^ DAC_MIDSCALE);
		end
	end

	assign dac_pos = dac_pos_q;
	assign dac_neg = dac_neg_q;

endmodule

`default_nettype wire

// file: src/dsc_pkg.sv
// constants and types shared by the synthesizer core
package dsc_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0]  OFS_CTRL = 8'h00;
	localparam logic [7:0]  OFS_TUNE  = 8'h04;
	localparam logic [7:0]  OFS_PHASE = 8'h08;
	localparam logic [7:0]  OFS_SCALE = 8'h0c;
	localparam logic [7:0]  OFS_AUX  = 8'h10;
	localparam logic [7:0]  OFS_STAT = 8'h14;

	localparam int          CTRL_MOD_EN_BIT = 0;
	localparam int          CTRL_SINE_BIT   = 16;
	localparam int          CTRL_ISINC_BIT  = 22;

	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] TUNE_RST  = 32'h0000_0000;
	localparam logic [15:0] PHASE_RST = 16'h0000;
	localparam logic [13:0] SCALE_RST = 14'h3fff;
	localparam logic [7:0]  AUX_RST  = 8'h7f;

	typedef enum logic [2:0] {
		REG_CTRL = 3'b000,
		REG_TUNE  = 3'b001,
		REG_PHASE = 3'b010,
		REG_SCALE = 3'b011,
		REG_AUX  = 3'b100,
		REG_STAT = 3'b101,
		REG_NONE = 3'b111
	} dsc_reg_t;

	// ****************************************
	// modulation stream
	// ****************************************
	localparam logic [1:0]  DEST_FREQ  = 2'h1;
	localparam logic [1:0]  DEST_PHASE = 2'h2;
	localparam logic [1:0]  DEST_AMP   = 2'h3;
	localparam logic [1:0]  MOD_DIV    = 2'h3;
	localparam int          FIFO_DEPTH = 16;

	typedef struct packed {
		logic [1:0]  dest;
		logic [31:0] value;
	} dsc_mod_sample_t;

	// ****************************************
	// datapath
	// ****************************************
	localparam logic [15:0] QUARTER_TURN = 16'h4000;
	localparam logic [15:0] HALF_TURN    = 16'h8000;
	localparam logic [13:0] MAG_MAX      = 14'h1fff;
	localparam logic [13:0] DAC_MIDSCALE = 14'h2000;
	localparam int          FIR_SHIFT    = 13;
	localparam logic signed [13:0] FIR_TAP [0:3] = '{-14'sd35, 14'sd134, -14'sd562, 14'sd6729};

endpackage

// file: bench/dsc_props.sv
// concurrent checks on the synthesizer core ports
`timescale 1ns/100ps
`default_nettype none
module dsc_props
	import dsc_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [13:0] dac_pos,
	input wire logic [13:0] dac_neg,
	input wire logic [7:0]  fsc_code
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence apb_setup;
		psel && !penable;
	endsequence
	sequence aux_write;
		apb_setup ##1 psel && penable && pready && pwrite && paddr == OFS_AUX;
	endsequence
	dac_pair_a: assert property (dac_neg == ~dac_pos)
		else $error("dac outputs not complementary");
	aux_write_a: assert property (aux_write |=> fsc_code == $past(pwdata[7:0]))
		else $error("full-scale code missed a write");
	fsc_hold_a: assert property (!$stable(fsc_code) |-> $past(psel && penable && pwrite && paddr == OFS_AUX))
		else $error("full-scale code changed without a write");
	fsc_reset_a: assert property ($rose(presetn) |-> fsc_code == AUX_RST)
		else $error("full-scale code not at reset value");
	setup_ready_a: assert property (apb_setup |=> pready)
		else $error("no ready after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	error_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	unmapped_err_a: assert property (apb_setup and paddr > OFS_STAT |=> pslverr && prdata == 32'h0)
		else $error("unmapped address not refused");
	mapped_ok_a: assert property (apb_setup and paddr <= OFS_STAT && paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("mapped address refused");
endmodule
bind dsc_core dsc_props dsc_props_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
	.pready, .pslverr, .dac_pos, .dac_neg, .fsc_code);
`default_nettype wire

// file: bench/dsc_dac_model.sv
// behavioural dac and load seen from the core's sample outputs
`timescale 1ns/100ps
`default_nettype none
module dsc_dac_model (
	input  wire logic        pclk,
	input  wire logic [13:0] dac_pos,
	input  wire logic [13:0] dac_neg,
	input  wire logic [7:0]  fsc_code,
	output var  int          sample,
	output var  logic        balanced,
	output var  int          full_scale_ua
);
	always_ff @(posedge pclk) begin
		sample <= int'($signed(dac_pos ^ 14'h2000));
		balanced <= ((dac_pos ^ dac_neg) === 14'h3fff);
	end
	// aux code sets current, nominal 10k set resistor
	assign full_scale_ua = 8640 * (96 + int'(fsc_code)) / 96;
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// self-checking bench for the synthesizer core
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import dsc_pkg::*;
	logic            pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mod_valid = 0;
	logic [7:0]      paddr = '0;
	logic [31:0]     pwdata = '0, prdata, rd, d;
	logic            pready, pslverr, mod_ready, er, bal;
	logic [13:0]     dac_pos, dac_neg;
	logic [7:0]      fsc_code;
	dsc_mod_sample_t mod_sample = '0;
	int              bad_count = 0, checks = 0, cyc = 0, t0, ta, a, n, i, smp, fsu;
	// words are whole integers; the last one is above the dc-to-nyquist range on purpose
	logic [31:0]     tune [3] = '{32'h0001_0000, 32'h0003_0000, 32'hffff_0000};
	int              ctl [5] = '{32'h10000, 32'h10000, 0, 32'h400000, 32'h10000};
	int              ph  [5] = '{0, 32'h4000, 0, 0, 32'h4000};
	int              scl [5] = '{32'h2000, 32'h2000, 32'h2000, 32'h2000, 0};
	int              ex  [5] = '{0, 4096, 4096, 2901, 0};
	dsc_core dsc_core_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .mod_valid, .mod_sample, .mod_ready, .dac_pos, .dac_neg, .fsc_code);
	dsc_dac_model dsc_dac_model_i (.pclk, .dac_pos, .dac_neg, .fsc_code, .sample(smp), .balanced(bal),
		.full_scale_ua(fsu));
	initial forever #2.5 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// one apb transfer; t0 records the edge where ready was seen
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		int k;
		psel <= 1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			bad_count++;
			end_of_test();
		end
		rd = prdata;
		er = pslverr;
		t0 = cyc;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	initial begin
		a = $urandom(32'h5aa8991e);
		repeat (8) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, OFS_AUX, 0);
		check(rd, 32'h7f);
		check(fsu, 20070);
		apb(0, OFS_SCALE, 0);
		check(rd, 32'h3fff);
		apb(0, 8'h18, 0);
		check(er, 1);
		check(rd, 0);
		d = $urandom;
		apb(1, OFS_AUX, d);
		apb(0, OFS_AUX, 0);
		check(rd, {24'h0, d[7:0]});
		check(fsc_code, d[7:0]);
		$display("test registers done");
		// accumulator stride, including an aliasing word
		for (i = 0; i < 3; i++) begin
			apb(1, OFS_TUNE, tune[i]);
			apb(0, OFS_STAT, 0);
			a = rd[31:16];
			ta = t0;
			repeat ($urandom_range(9, 1)) @(posedge pclk);
			apb(0, OFS_STAT, 0);
			check(rd[31:16], 16'(a + (t0 - ta) * tune[i][31:16]));
		end
		$display("test accumulator done");
		apb(1, OFS_TUNE, 0);
		apb(0, OFS_STAT, 0);
		a = rd[31:16];
		for (i = 0; i < 5; i++) begin
			apb(1, OFS_CTRL, ctl[i]);
			apb(1, OFS_PHASE, {16'h0, 16'(ph[i] - a)});
			apb(1, OFS_SCALE, scl[i]);
			repeat (30) @(posedge pclk);
			check((smp - ex[i]) <= 8 && (ex[i] - smp) <= 8, 1);
			check(bal, 1);
		end
		$display("test waveform done");
		// fifo held full while draining is off
		apb(1, OFS_CTRL, 0);
		n = 0;
		mod_valid <= 1;
		for (i = 0; i < 24; i++) begin
			mod_sample <= {2'h0, $urandom};
			@(posedge pclk);
			if (mod_ready === 1'b1)
				n++;
		end
		mod_valid <= 0;
		check(n, FIFO_DEPTH);
		apb(0, OFS_STAT, 0);
		check(rd[4:0], 16);
		apb(1, OFS_CTRL, 1);
		ta = t0;
		apb(0, OFS_STAT, 0);
		check((16 - rd[4:0]) <= (t0 - ta) / 4 + 1, 1);
		for (i = 0; i < 40 && rd[4:0] != 0; i++)
			apb(0, OFS_STAT, 0);
		check(rd[4:0], 0);
		check(mod_ready, 1);
		$display("test fifo done");
		// stream samples steer scale and phase once modulation is on
		apb(1, OFS_CTRL, 32'h10001);
		mod_sample <= {DEST_AMP, 32'h0000_2000};
		mod_valid <= 1;
		@(posedge pclk);
		mod_valid <= 0;
		repeat (30) @(posedge pclk);
		check((smp - 4096) <= 8 && (4096 - smp) <= 8, 1);
		mod_sample <= {DEST_PHASE, 16'h0000, 16'(0 - a)};
		mod_valid <= 1;
		@(posedge pclk);
		mod_valid <= 0;
		repeat (30) @(posedge pclk);
		check(smp <= 8 && smp >= -8, 1);
		$display("test modulation done");
		end_of_test();
	end
endmodule
`default_nettype wire
